// ---- rtl/fiap_pkg.sv ----
// Purpose: constants and carriers for the flash erase/write controller
// Assumes: 250 MHz clk, byte-wide register port
// Notes: op and window times are counted in clk cycles derived from clk_mhz
// Operation
// RULE1: high address keeps five bits, upper three read zero
// RULE2: low load byte write only stores the byte
// RULE3: high load byte write stores the word in buffer and bumps address
// RULE4: address holds at last word of page, no further increment
// RULE5: dummy high-byte writes tag words for page erase; only tagged erased
// RULE6: software blank-checks erased page and repeats erase if not zero
// RULE7: software clears buffer, reloads and rewrites on verify mismatch
// RULE8: hardware sets enabled status on good unlock; erase/write need it
// RULE9: software selects unlock mode 110 before setting unlock trigger
// RULE10: unlock trigger starts a timer bounding the pattern window
// RULE11: unlock pattern 00 0d c3 / 04 09 40 must match exactly
// RULE12: trigger clears itself when the timer expires, pattern regardless
// RULE13: wrong pattern leaves erase/write disabled
// RULE14: software clearing enabled status disables erase/write at once
// RULE15: buffer holds 32 words of the page given by address bits 12..5
// RULE16: software loads at most 32 words low byte first
// RULE17: software erases a page before writing it
// RULE18: mode codes: write 000, page erase 001, read 011
// RULE19: hardware clears write start when erase or write completes
// RULE20: time select: 3.2/2.2 ms when clear, 3.7/3.0 ms when set
// RULE21: whole write buffer cleared after each write finishes
// RULE22: pattern compared only while timer runs; later writes ignored
package fiap_pkg;
  localparam logic [3:0] reg_ctrl = 4'h0;
  localparam logic [3:0] reg_timing = 4'h2;
  localparam logic [3:0] reg_addr_low = 4'h3;
  localparam logic [3:0] reg_addr_high = 4'h4;
  localparam logic [3:0] reg_load_low = 4'h5;
  localparam logic [3:0] reg_load_high = 4'h6;
  localparam logic [3:0] reg_unl_a_low = 4'h7;
  localparam logic [3:0] reg_unl_a_high = 4'h8;
  localparam logic [3:0] reg_unl_b_low = 4'h9;
  localparam logic [3:0] reg_unl_b_high = 4'ha;
  localparam logic [3:0] reg_unl_c_low = 4'hb;
  localparam logic [3:0] reg_unl_c_high = 4'hc;
  localparam int bit_enabled = 7;
  localparam int bit_mode_lo = 4;
  localparam int bit_trigger = 3;
  localparam int bit_start = 2;
  localparam int bit_tsel = 1;
  localparam int bit_bclr = 0;
  localparam logic [2:0] mode_write = 3'h0;
  localparam logic [2:0] mode_erase = 3'h1;
  localparam logic [2:0] mode_read = 3'h3;
  localparam logic [2:0] mode_unlock = 3'h6;
  localparam logic [47:0] unlock_pattern = 48'h00_04_0d_09_c3_40;
  localparam logic [4:0] page_last = 5'h1f;
  localparam int words = 32;
  localparam real clk_mhz = 250.0;
  localparam real erase_short_us = 3200.0;
  localparam real erase_long_us = 3700.0;
  localparam real write_short_us = 2200.0;
  localparam real write_long_us = 3000.0;
  localparam real unlock_us = 8.0;
  localparam int erase_short_cyc = int'(erase_short_us * clk_mhz);
  localparam int erase_long_cyc = int'(erase_long_us * clk_mhz);
  localparam int write_short_cyc = int'(write_short_us * clk_mhz);
  localparam int write_long_cyc = int'(write_long_us * clk_mhz);
  localparam int unlock_cyc = int'(unlock_us * clk_mhz);
  typedef enum logic [1:0]
  {
    fiap_idle = 2'b00,
    fiap_busy = 2'b01,
    fiap_clear = 2'b10
  } fiap_state_t;
  typedef struct packed
  {
    logic wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } fiap_bus_t;
  typedef struct packed
  {
    logic prog;
    logic erase;
    logic [12:0] addr;
    logic [15:0] data;
  } fiap_flash_t;
endpackage

// ---- rtl/fiap_buffer.sv ----
// Purpose: 32-word page buffer with per-word tag bits
// Assumes: one write and one read port, same clock
// Notes: read data registered; clear wipes all tags and data in one cycle
`timescale 1ns/1ps
module fiap_buffer
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // write side
  input wire logic wr,
  input wire logic [4:0] waddr,
  input wire logic [15:0] wdata,
  input wire logic clr,
  // read side
  input wire logic [4:0] raddr,
  output logic [15:0] rdata,
  output logic rtag
);
  logic [15:0] mem [0:31];
  logic [31:0] tag;
  genvar i;
  generate
    for (i = 0; i < 32; i++)
    begin : g_word
      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
        begin
          mem[i] <= 16'h0000;
          tag[i] <= 1'b0;
        end
        else if (clr)
        begin
          mem[i] <= 16'h0000;
          tag[i] <= 1'b0;
        end
        else if (wr && waddr == 5'(i))
        begin
          mem[i] <= wdata;
          tag[i] <= 1'b1;
        end
      end
    end
  endgenerate
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rdata <= 16'h0000;
      rtag <= 1'b0;
    end
    else
    begin
      rdata <= mem[raddr];
      rtag <= tag[raddr];
    end
  end
endmodule

// ---- rtl/fiap_ctrl.sv ----
// Purpose: in-application erase/write control of program flash
// Assumes: byte register port from the cpu, flash array strobes outward
// Notes: during a busy erase/write the array gets one strobe per tagged word
`timescale 1ns/1ps
module fiap_ctrl
#(
  parameter int erase_short = fiap_pkg::erase_short_cyc,
  parameter int erase_long = fiap_pkg::erase_long_cyc,
  parameter int write_short = fiap_pkg::write_short_cyc,
  parameter int write_long = fiap_pkg::write_long_cyc
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire fiap_pkg::fiap_bus_t bus,
  output logic [7:0] rdata,
  // flash array
  output fiap_pkg::fiap_flash_t flash,
  output logic busy
);
  typedef struct packed
  {
    fiap_pkg::fiap_state_t st;
    logic enabled;
    logic [2:0] mode;
    logic trigger;
    logic start;
    logic tsel;
    logic bclr;
    logic [12:0] addr;
    logic [15:0] load;
    logic [47:0] unl;
    logic [15:0] utimer;
    logic [21:0] ptimer;
    logic [5:0] scan;
    logic scan_v;
    logic [7:0] rdata;
    fiap_pkg::fiap_flash_t flash;
    logic busy;
  } fiap_ctrl_t;
  fiap_ctrl_t s, next_s;
  logic [15:0] buf_rdata;
  logic buf_rtag;
  logic buf_wr;
  logic buf_clr;
  logic [4:0] buf_raddr;
  logic [21:0] op_len;
  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_s = s;
    buf_wr = 1'b0;
    buf_clr = 1'b0;
    buf_raddr = s.scan[4:0];
    next_s.flash.prog = 1'b0;
    next_s.flash.erase = 1'b0;
    if (s.mode == fiap_pkg::mode_erase) // RULE18 RULE20
      op_len = s.tsel ? 22'(erase_long) : 22'(erase_short);
    else
      op_len = s.tsel ? 22'(write_long) : 22'(write_short);
    // unlock timer counts only while the trigger stands
    if (s.trigger)
    begin
      if (s.utimer == 16'h0000)
        next_s.trigger = 1'b0; // RULE12
      else
        next_s.utimer = s.utimer - 16'h0001; // RULE10
    end
    if (s.trigger && s.mode == fiap_pkg::mode_unlock && s.unl == fiap_pkg::unlock_pattern)
    begin
      next_s.enabled = 1'b1; // RULE8 RULE11 RULE13 RULE22
      next_s.trigger = 1'b0;
    end
    if (bus.wr)
    begin
      case (bus.addr)
        fiap_pkg::reg_ctrl:
        begin
          if (!bus.wdata[fiap_pkg::bit_enabled])
            next_s.enabled = 1'b0; // RULE14
          next_s.mode = bus.wdata[fiap_pkg::bit_mode_lo +: 3];
          if (bus.wdata[fiap_pkg::bit_trigger] && !s.trigger)
          begin
            next_s.trigger = 1'b1; // RULE10
            next_s.utimer = 16'(fiap_pkg::unlock_cyc);
            next_s.unl = 48'h0;
          end
          // start only takes effect while enabled in erase or write mode
          if (bus.wdata[fiap_pkg::bit_start] && s.enabled && s.st == fiap_pkg::fiap_idle &&
              (bus.wdata[6:4] == fiap_pkg::mode_write || bus.wdata[6:4] == fiap_pkg::mode_erase))
          begin
            next_s.start = 1'b1; // RULE8
            next_s.st = fiap_pkg::fiap_busy;
            next_s.ptimer = 22'h0;
            next_s.scan = 6'h00;
            next_s.scan_v = 1'b0;
          end
        end
        fiap_pkg::reg_timing:
        begin
          next_s.tsel = bus.wdata[fiap_pkg::bit_tsel];
          if (bus.wdata[fiap_pkg::bit_bclr] && s.st == fiap_pkg::fiap_idle)
          begin
            next_s.bclr = 1'b1;
            next_s.st = fiap_pkg::fiap_clear;
          end
        end
        fiap_pkg::reg_addr_low: next_s.addr[7:0] = bus.wdata;
        fiap_pkg::reg_addr_high: next_s.addr[12:8] = bus.wdata[4:0]; // RULE1
        fiap_pkg::reg_load_low: next_s.load[7:0] = bus.wdata; // RULE2
        fiap_pkg::reg_load_high:
        begin
          next_s.load[15:8] = bus.wdata;
          if (s.enabled && s.st == fiap_pkg::fiap_idle)
          begin
            buf_wr = 1'b1; // RULE3 RULE5 RULE15
            if (s.addr[4:0] != fiap_pkg::page_last)
              next_s.addr = s.addr + 13'h0001; // RULE4
          end
        end
        // pattern writes land only while the window is open
        fiap_pkg::reg_unl_a_low: if (s.trigger) next_s.unl[47:40] = bus.wdata; // RULE22
        fiap_pkg::reg_unl_a_high: if (s.trigger) next_s.unl[39:32] = bus.wdata; // RULE22
        fiap_pkg::reg_unl_b_low: if (s.trigger) next_s.unl[31:24] = bus.wdata; // RULE22
        fiap_pkg::reg_unl_b_high: if (s.trigger) next_s.unl[23:16] = bus.wdata; // RULE22
        fiap_pkg::reg_unl_c_low: if (s.trigger) next_s.unl[15:8] = bus.wdata; // RULE22
        fiap_pkg::reg_unl_c_high: if (s.trigger) next_s.unl[7:0] = bus.wdata; // RULE22
        default: ;
      endcase
    end
    case (s.st)
      fiap_pkg::fiap_idle: ;
      fiap_pkg::fiap_busy:
      begin
        // strobe each tagged word once, data from the registered buffer read
        // scan runs on to 32 so the read of word 31 still meets its strobe, once
        next_s.scan_v = !s.scan[5];
        if (s.scan_v && buf_rtag)
        begin
          next_s.flash.prog = (s.mode == fiap_pkg::mode_write);
          next_s.flash.erase = (s.mode == fiap_pkg::mode_erase); // RULE5
          next_s.flash.addr = {s.addr[12:5], 5'(s.scan - 6'h01)}; // RULE15
          next_s.flash.data = buf_rdata;
        end
        if (!s.scan[5])
          next_s.scan = s.scan + 6'h01;
        if (s.ptimer + 22'h1 >= op_len)
        begin
          next_s.start = 1'b0; // RULE19
          next_s.st = fiap_pkg::fiap_idle;
          buf_clr = 1'b1; // RULE21
        end
        else
          next_s.ptimer = s.ptimer + 22'h1;
      end
      fiap_pkg::fiap_clear:
      begin
        buf_clr = 1'b1;
        next_s.bclr = 1'b0;
        next_s.st = fiap_pkg::fiap_idle;
      end
      default: next_s.st = fiap_pkg::fiap_idle;
    endcase
    next_s.busy = (next_s.st != fiap_pkg::fiap_idle);
    case (bus.addr)
      fiap_pkg::reg_ctrl: next_s.rdata = {s.enabled, s.mode, s.trigger, s.start, 2'b00};
      fiap_pkg::reg_timing: next_s.rdata = {6'h00, s.tsel, s.bclr};
      fiap_pkg::reg_addr_low: next_s.rdata = s.addr[7:0];
      fiap_pkg::reg_addr_high: next_s.rdata = {3'b000, s.addr[12:8]}; // RULE1
      fiap_pkg::reg_load_low: next_s.rdata = s.load[7:0];
      fiap_pkg::reg_load_high: next_s.rdata = s.load[15:8];
      fiap_pkg::reg_unl_a_low: next_s.rdata = s.unl[47:40];
      fiap_pkg::reg_unl_a_high: next_s.rdata = s.unl[39:32];
      fiap_pkg::reg_unl_b_low: next_s.rdata = s.unl[31:24];
      fiap_pkg::reg_unl_b_high: next_s.rdata = s.unl[23:16];
      fiap_pkg::reg_unl_c_low: next_s.rdata = s.unl[15:8];
      fiap_pkg::reg_unl_c_high: next_s.rdata = s.unl[7:0];
      default: next_s.rdata = 8'h00;
    endcase
  end
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      s <= '0;
    else
      s <= next_s;
  end
  assign rdata = s.rdata;
  assign flash = s.flash;
  assign busy = s.busy;
  fiap_buffer u_buf
  (
    .clk(clk),
    .rstn(rstn),
    .wr(buf_wr),
    .waddr(s.addr[4:0]),
    .wdata({bus.wdata, s.load[7:0]}),
    .clr(buf_clr),
    .raddr(buf_raddr),
    .rdata(buf_rdata),
    .rtag(buf_rtag)
  );
  ////////////////////////////////////////////////////////////////////////////
  sequence load_hi_s;
    bus.wr && bus.addr == fiap_pkg::reg_load_high && s.enabled && s.st == fiap_pkg::fiap_idle;
  endsequence
  sequence start_s;
    bus.wr && bus.addr == fiap_pkg::reg_ctrl && bus.wdata[fiap_pkg::bit_start]
      && s.st == fiap_pkg::fiap_idle;
  endsequence
  addr_high_zero_a: assert property (@(posedge clk) disable iff (!rstn) // RULE1
    !bus.wr && bus.addr == fiap_pkg::reg_addr_high |=> rdata[7:5] == 3'b000)
    else $error("high address upper bits not zero");
  low_no_move_a: assert property (@(posedge clk) disable iff (!rstn) // RULE2
    bus.wr && bus.addr == fiap_pkg::reg_load_low && s.st == fiap_pkg::fiap_idle |=> $stable(s.addr))
    else $error("low byte write moved address");
  addr_bump_a: assert property (@(posedge clk) disable iff (!rstn) // RULE3
    load_hi_s ##0 (s.addr[4:0] != 5'h1f) |=> s.addr == $past(s.addr) + 13'h0001)
    else $error("address not incremented");
  addr_hold_a: assert property (@(posedge clk) disable iff (!rstn) // RULE4
    load_hi_s ##0 (s.addr[4:0] == 5'h1f) |=> $stable(s.addr))
    else $error("address passed page end");
  need_enable_a: assert property (@(posedge clk) disable iff (!rstn) // RULE8
    start_s ##0 !s.enabled |=> !s.start && !busy)
    else $error("operation started while disabled");
  trig_clear_a: assert property (@(posedge clk) disable iff (!rstn) // RULE12
    s.trigger && s.utimer == 16'h0000 |=> !s.trigger)
    else $error("trigger stuck after timeout");
  dis_now_a: assert property (@(posedge clk) disable iff (!rstn) // RULE14
    bus.wr && bus.addr == fiap_pkg::reg_ctrl && !bus.wdata[7] |=> !s.enabled)
    else $error("disable not immediate");
  unlock_gate_a: assert property (@(posedge clk) disable iff (!rstn) // RULE22
    !s.enabled && !s.trigger |=> !s.enabled)
    else $error("enabled without open window");
  done_clear_a: assert property (@(posedge clk) disable iff (!rstn) // RULE19
    s.start && s.st == fiap_pkg::fiap_idle |-> 1'b0)
    else $error("start left high after completion");
  ////////////////////////////////////////////////////////////////////////////
  // unlock window and gating
  sequence ctrl_wr_s;
    bus.wr && bus.addr == fiap_pkg::reg_ctrl;
  endsequence
  sequence op_end_s;
    s.st == fiap_pkg::fiap_busy && s.ptimer + 22'h1 >= op_len;
  endsequence
  sequence strobe_s;
    flash.prog || flash.erase;
  endsequence
  trig_arm_a: assert property (@(posedge clk) disable iff (!rstn) // RULE10
    ctrl_wr_s ##0 (bus.wdata[fiap_pkg::bit_trigger] && !s.trigger)
      |=> s.trigger && s.utimer == 16'(fiap_pkg::unlock_cyc))
    else $error("trigger did not arm the window timer");
  trig_count_a: assert property (@(posedge clk) disable iff (!rstn) // RULE10
    s.trigger && s.utimer != 16'h0000 && s.unl != fiap_pkg::unlock_pattern
      |=> s.trigger && s.utimer == $past(s.utimer) - 16'h0001)
    else $error("window timer did not count down");
  unlock_set_a: assert property (@(posedge clk) disable iff (!rstn) // RULE8 RULE11
    s.trigger && s.mode == fiap_pkg::mode_unlock && s.unl == fiap_pkg::unlock_pattern
      && !(bus.wr && bus.addr == fiap_pkg::reg_ctrl) |=> s.enabled && !s.trigger)
    else $error("good pattern did not enable");
  bad_pattern_a: assert property (@(posedge clk) disable iff (!rstn) // RULE13
    !s.enabled && s.unl != fiap_pkg::unlock_pattern |=> !s.enabled)
    else $error("enabled on a wrong pattern");
  unl_ignore_a: assert property (@(posedge clk) disable iff (!rstn) // RULE22
    bus.wr && bus.addr >= fiap_pkg::reg_unl_a_low && bus.addr <= fiap_pkg::reg_unl_c_high
      && !s.trigger |=> $stable(s.unl))
    else $error("pattern write taken outside window");
  load_refuse_a: assert property (@(posedge clk) disable iff (!rstn) // RULE8
    bus.wr && bus.addr == fiap_pkg::reg_load_high && !s.enabled
      |=> $stable(s.addr) && !$past(buf_wr))
    else $error("load taken while disabled");
  ////////////////////////////////////////////////////////////////////////////
  // erase/write runs and array strobes
  start_go_a: assert property (@(posedge clk) disable iff (!rstn) // RULE8 RULE18
    start_s ##0 (s.enabled && (bus.wdata[6:4] == fiap_pkg::mode_write
      || bus.wdata[6:4] == fiap_pkg::mode_erase)) |=> s.start && busy)
    else $error("enabled start did not run");
  mode_refuse_a: assert property (@(posedge clk) disable iff (!rstn) // RULE18
    start_s ##0 (bus.wdata[6:4] != fiap_pkg::mode_write
      && bus.wdata[6:4] != fiap_pkg::mode_erase) |=> !s.start && !busy)
    else $error("reserved mode started a run");
  op_end_a: assert property (@(posedge clk) disable iff (!rstn) // RULE19
    op_end_s |=> !s.start && !busy)
    else $error("start not cleared at end of run");
  op_bound_a: assert property (@(posedge clk) disable iff (!rstn) // RULE20
    s.st == fiap_pkg::fiap_busy |-> s.ptimer < op_len)
    else $error("run longer than selected time");
  wipe_a: assert property (@(posedge clk) disable iff (!rstn) // RULE21
    op_end_s |=> ##1 !buf_rtag)
    else $error("buffer tags survive end of run");
  strobe_excl_a: assert property (@(posedge clk) disable iff (!rstn) // RULE5
    strobe_s |-> !(flash.prog && flash.erase) && $past(busy))
    else $error("array strobe outside a run");
  tag_only_a: assert property (@(posedge clk) disable iff (!rstn) // RULE5
    strobe_s |-> $past(buf_rtag) && $past(s.scan_v))
    else $error("untagged word strobed");
  page_keep_a: assert property (@(posedge clk) disable iff (!rstn) // RULE15
    strobe_s |-> flash.addr[12:5] == $past(s.addr[12:5]))
    else $error("strobe left the selected page");
endmodule

// ---- testbench/flash_iap_erase_write_control_test.sv ----
// Purpose: self-checking bench for the flash erase/write controller
// Assumes: short op-time parameters, falling-edge stimulus
// Notes: strobes are counted at rising edges; op spans allow a few cycles of slack
`timescale 1ns/1ps
module flash_iap_erase_write_control_test;
  localparam int e_short = 64;
  localparam int e_long = 96;
  localparam int w_short = 40;
  localparam int w_long = 56;
  logic clk;
  logic rstn;
  fiap_pkg::fiap_bus_t bus;
  logic [7:0] rdata;
  fiap_pkg::fiap_flash_t flash;
  logic busy;
  int bad_count;
  int checks_done;
  int prog_n;
  int erase_n;
  logic [15:0] last_data;
  logic [12:0] first_addr;

  fiap_ctrl #(.erase_short(e_short), .erase_long(e_long), .write_short(w_short),
    .write_long(w_long)) dut_u (.clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata),
    .flash(flash), .busy(busy));

  always #2 clk = ~clk;

  always @(posedge clk)
  begin
    if (flash.prog === 1'b1 || flash.erase === 1'b1)
    begin
      if (prog_n + erase_n == 0)
        first_addr <= flash.addr;
      if (flash.prog === 1'b1)
        prog_n <= prog_n + 1;
      else
        erase_n <= erase_n + 1;
      last_data <= flash.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    bus.wr = 1'b1;
    bus.addr = a;
    bus.wdata = d;
    @(negedge clk);
    bus.wr = 1'b0;
  endtask

  // read data is registered, so it is sampled one full cycle after the index
  task automatic chk_reg(input string what, input logic [3:0] a, input logic [7:0] exp);
    @(negedge clk);
    bus.addr = a;
    @(negedge clk);
    check(what, {8'h00, rdata}, {8'h00, exp});
  endtask

  task automatic unlock(input logic trig, input logic [7:0] last);
    if (trig)
      wr(fiap_pkg::reg_ctrl, 8'h68);
    for (int i = 0; i < 6; i++)
      wr(4'(7 + i), (i == 5) ? last : fiap_pkg::unlock_pattern[47 - 8 * i -: 8]);
  endtask

  task automatic run_op(input logic [7:0] ctrl, input int p, input logic exp);
    int n;
    int dur;
    prog_n = 0;
    erase_n = 0;
    wr(fiap_pkg::reg_ctrl, ctrl);
    n = 0;
    dur = 0;
    while (busy !== 1'b1 && n < 4)
    begin
      @(negedge clk);
      n++;
    end
    while (busy === 1'b1 && dur < 2000)
    begin
      @(negedge clk);
      dur++;
    end
    check("busy seen", 16'(n < 4), 16'(exp));
    if (exp)
      check("op span", 16'(dur >= p - 3 && dur <= p + 3), 16'h0001);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_addr_bits();
    chk_reg("addr high reset", fiap_pkg::reg_addr_high, 8'h00);
    wr(fiap_pkg::reg_addr_high, 8'hff);
    chk_reg("addr high upper", fiap_pkg::reg_addr_high, 8'h1f);
    chk_reg("unmapped", 4'hf, 8'h00);
  endtask

  task automatic t_unlock();
    wr(fiap_pkg::reg_load_high, 8'h55);
    chk_reg("locked load", fiap_pkg::reg_addr_low, 8'h00);
    unlock(1'b1, 8'h41);
    chk_reg("bad pattern", fiap_pkg::reg_ctrl, 8'h68);
    repeat (2100) @(negedge clk);
    chk_reg("trigger expiry", fiap_pkg::reg_ctrl, 8'h60);
    unlock(1'b0, 8'h40);
    chk_reg("late pattern", fiap_pkg::reg_ctrl, 8'h60);
    chk_reg("late ignored", fiap_pkg::reg_unl_c_high, 8'h41);
    unlock(1'b1, 8'h40);
    chk_reg("good pattern", fiap_pkg::reg_ctrl, 8'he0);
  endtask

  task automatic t_write();
    wr(fiap_pkg::reg_timing, 8'h00);
    wr(fiap_pkg::reg_addr_high, 8'h01);
    wr(fiap_pkg::reg_addr_low, 8'h3e);
    repeat (2) wr(fiap_pkg::reg_load_high, 8'h00);
    run_op(8'h94, e_short, 1'b1);
    check("pre-erase count", 16'(erase_n), 16'h0002);
    wr(fiap_pkg::reg_addr_low, 8'h3e);
    wr(fiap_pkg::reg_load_low, 8'h34);
    chk_reg("low only", fiap_pkg::reg_addr_low, 8'h3e);
    wr(fiap_pkg::reg_load_high, 8'h12);
    chk_reg("addr bump", fiap_pkg::reg_addr_low, 8'h3f);
    wr(fiap_pkg::reg_load_low, 8'h78);
    wr(fiap_pkg::reg_load_high, 8'h56);
    wr(fiap_pkg::reg_load_high, 8'h9a);
    chk_reg("addr hold", fiap_pkg::reg_addr_low, 8'h3f);
    chk_reg("addr high", fiap_pkg::reg_addr_high, 8'h01);
    chk_reg("load low", fiap_pkg::reg_load_low, 8'h78);
    run_op(8'h84, w_short, 1'b1);
    check("prog count", 16'(prog_n), 16'h0002);
    check("prog addr", {3'h0, first_addr}, 16'h013e);
    check("prog data", last_data, 16'h9a78);
    chk_reg("start done", fiap_pkg::reg_ctrl, 8'h80);
    run_op(8'h84, w_short, 1'b1);
    check("buffer wiped", 16'(prog_n), 16'h0000);
  endtask

  task automatic t_erase();
    wr(fiap_pkg::reg_timing, 8'h03);
    repeat (3) @(negedge clk);
    chk_reg("clear done", fiap_pkg::reg_timing, 8'h02);
    wr(fiap_pkg::reg_addr_low, 8'h40);
    repeat (3) wr(fiap_pkg::reg_load_high, 8'h00);
    chk_reg("tag addr", fiap_pkg::reg_addr_low, 8'h43);
    run_op(8'h94, e_long, 1'b1);
    check("erase count", 16'(erase_n), 16'h0003);
    check("erase addr", {3'h0, first_addr}, 16'h0140);
    run_op(8'hb4, 0, 1'b0);
  endtask

  task automatic t_disable();
    wr(fiap_pkg::reg_ctrl, 8'h00);
    chk_reg("disabled", fiap_pkg::reg_ctrl, 8'h00);
    wr(fiap_pkg::reg_load_high, 8'h11);
    chk_reg("no bump", fiap_pkg::reg_addr_low, 8'h43);
    run_op(8'h14, 0, 1'b0);
    check("no erase", 16'(erase_n), 16'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    bus = '0;
    prog_n = 0;
    erase_n = 0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    t_addr_bits();
    t_unlock();
    t_write();
    t_erase();
    t_disable();
    tally_and_finish();
  end

  // the whole run needs about 2500 cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end
endmodule
